/* File: hdl/ddrc_pkg.sv */
// constants and helpers shared by the ddr2 column access block
package ddrc_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int PAGE_COLS = 512;
  localparam int SEG_BL4 = 128;
  localparam int SEG_BL8 = 64;

  // ****************************************
  // mode register fields
  // ****************************************
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] LAST_BL4 = 3'h3;
  localparam logic [2:0] LAST_BL8 = 3'h7;
  localparam int MAX_AL = 6;
  localparam int MAX_CL = 6;
  localparam int MAX_RL = MAX_AL + MAX_CL;
  localparam int PREAMBLE_CYC = 1;
  localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_PRE = 2'b01,
    RD_DATA = 2'b10
  } ddrc_rd_t;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_DATA = 1'b1
  } ddrc_wr_t;

  // column of a given beat: wraps inside the aligned segment only
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
    input logic [2:0] beat, input logic bl8, input logic il);
    logic [2:0] lo;
    lo = il ? (start[2:0] ^ beat)
            : {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
    if (!bl8)
      lo[2] = start[2];
    return {start[COL_W-1:3], lo};
  endfunction

endpackage

/* File: hdl/ddrc_col_access.sv */
// ddr2 column access: command decode, posted cas, burst read and write paths
`timescale 1ns/1ps
`default_nettype none
module ddrc_col_access #(
  parameter int COLS = ddrc_pkg::PAGE_COLS
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ck, // memory link clock
  input wire logic cs_n, // chip select, low active
  input wire logic ras_n, // row strobe, low active
  input wire logic cas_n, // column strobe, low active
  input wire logic we_n, // write enable, low active
  input wire logic [ddrc_pkg::COL_W-1:0] column_address_bits, // start column
  input wire logic [ddrc_pkg::DQ_W-1:0] dq_i, // data pin in
  output logic [ddrc_pkg::DQ_W-1:0] dq_o, // data pin out
  output logic dq_oe, // data pin drive
  input wire logic [ddrc_pkg::DM_W-1:0] dm_i, // write mask, one per byte
  input wire logic dqs_i, // strobe pin in
  output logic dqs_o, // strobe pin out
  output logic dqs_oe, // strobe pin drive
  input wire logic [2:0] burst_length, // mode register length code
  input wire logic burst_interleave, // mode register burst type
  input wire logic [2:0] cas_latency, // mode register, 2..6
  input wire logic [2:0] additive_latency, // extended mode register one, 0..6
  output logic rd_busy, // read burst on the pins
  output logic wr_busy // write burst being taken
);

  localparam int SW = 5 + ddrc_pkg::COL_W + ddrc_pkg::DQ_W + ddrc_pkg::DM_W + 1;
  localparam int RLW = 4;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic ck3_q;
  logic dqs3_q;
  logic ck_s;
  logic cs_s;
  logic ras_s;
  logic cas_s;
  logic we_s;
  logic [ddrc_pkg::COL_W-1:0] col_s;
  logic [ddrc_pkg::DQ_W-1:0] dqi_s;
  logic [ddrc_pkg::DM_W-1:0] dm_s;
  logic dqs_s;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      ck3_q <= 1'b0;
      dqs3_q <= 1'b0;
    end
    else
    begin
      s1_q <= {ck, cs_n, ras_n, cas_n, we_n, column_address_bits, dq_i, dm_i, dqs_i};
      s2_q <= s1_q;
      ck3_q <= ck_s;
      dqs3_q <= dqs_s;
    end
  end

  assign {ck_s, cs_s, ras_s, cas_s, we_s, col_s, dqi_s, dm_s, dqs_s} = s2_q;

  logic rise_ev;
  logic fall_ev;
  logic dqs_r;
  logic dqs_f;
  assign rise_ev = ck_s & ~ck3_q;
  assign fall_ev = ~ck_s & ck3_q;
  assign dqs_r = dqs_s & ~dqs3_q;
  assign dqs_f = ~dqs_s & dqs3_q;

  // ****************************************
  // command decode
  // ****************************************
  // only read and write are decoded; other commands belong elsewhere
  logic col_cmd;
  logic new_rd;
  logic new_wr;
  assign col_cmd = rise_ev && !cs_s && ras_s && !cas_s;
  assign new_rd = col_cmd && we_s;
  assign new_wr = col_cmd && !we_s;

  logic bl8;
  logic [2:0] last_beat;
  logic [RLW-1:0] rl;
  logic [RLW-1:0] wl_m1;
  assign bl8 = (burst_length == ddrc_pkg::BL8_CODE);
  assign last_beat = bl8 ? ddrc_pkg::LAST_BL8 : ddrc_pkg::LAST_BL4;
  // cas latency below 2 is not a legal setting and is not guarded
  assign rl = RLW'(additive_latency) + RLW'(cas_latency);
  assign wl_m1 = rl - RLW'(2);

  // ****************************************
  // posted cas pipeline, one stage per link cycle
  // ****************************************
  logic [ddrc_pkg::MAX_RL:1] prd_q;
  logic [ddrc_pkg::MAX_RL:1] pwr_q;
  logic [ddrc_pkg::COL_W-1:0] pcol_q [1:ddrc_pkg::MAX_RL];
  logic [ddrc_pkg::MAX_RL:0] age_rd;
  logic [ddrc_pkg::MAX_RL:0] age_wr;
  logic [ddrc_pkg::COL_W-1:0] age_col [0:ddrc_pkg::MAX_RL];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prd_q <= '0;
      pwr_q <= '0;
      for (int i = 1; i <= ddrc_pkg::MAX_RL; i++)
        pcol_q[i] <= '0;
    end
    else if (rise_ev)
    begin
      // commands are taken during the activate delay and held here
      prd_q <= {prd_q[ddrc_pkg::MAX_RL-1:1], new_rd};
      pwr_q <= {pwr_q[ddrc_pkg::MAX_RL-1:1], new_wr};
      pcol_q[1] <= col_s;
      for (int i = 2; i <= ddrc_pkg::MAX_RL; i++)
        pcol_q[i] <= pcol_q[i-1];
    end
  end

  always_comb
  begin
    age_rd = {prd_q, new_rd};
    age_wr = {pwr_q, new_wr};
    age_col[0] = col_s;
    for (int i = 1; i <= ddrc_pkg::MAX_RL; i++)
      age_col[i] = pcol_q[i];
  end

  logic rd_due;
  logic rd_pre;
  logic wr_arm;
  assign rd_due = rise_ev && age_rd[rl];
  assign rd_pre = rise_ev && age_rd[rl - RLW'(ddrc_pkg::PREAMBLE_CYC)];
  assign wr_arm = rise_ev && age_wr[wl_m1];

  // ****************************************
  // page storage
  // ****************************************
  logic [ddrc_pkg::DQ_W-1:0] mem_q [0:COLS-1];
  logic wr_cap;
  logic [ddrc_pkg::COL_W-1:0] wcol;
  logic [ddrc_pkg::COL_W-1:0] rcol_next;

  // ****************************************
  // read path
  // ****************************************
  ddrc_pkg::ddrc_rd_t rd_st_q;
  logic [2:0] rd_beat_q;
  logic [ddrc_pkg::COL_W-1:0] rd_start_q;

  assign rcol_next = ddrc_pkg::burst_col(rd_start_q, rd_beat_q + 3'h1, bl8,
                                         burst_interleave);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_st_q <= ddrc_pkg::RD_IDLE;
      rd_beat_q <= 3'h0;
      rd_start_q <= '0;
      dq_o <= ddrc_pkg::DQ_RST;
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe <= 1'b0;
      rd_busy <= 1'b0;
    end
    else if (rise_ev)
    begin
      if (rd_due)
      begin
        // a read that falls due replaces any burst in progress, at whatever beat it has reached
        rd_st_q <= ddrc_pkg::RD_DATA;
        rd_beat_q <= 3'h0;
        rd_start_q <= age_col[rl];
        dq_o <= mem_q[age_col[rl]];
        dq_oe <= 1'b1;
        dqs_o <= 1'b1;
        dqs_oe <= 1'b1;
        rd_busy <= 1'b1;
      end
      else if (rd_st_q == ddrc_pkg::RD_DATA && rd_beat_q != last_beat)
      begin
        rd_beat_q <= rd_beat_q + 3'h1;
        dq_o <= mem_q[rcol_next];
        dqs_o <= 1'b1;
      end
      else
      begin
        case (rd_st_q)
          ddrc_pkg::RD_IDLE, ddrc_pkg::RD_DATA:
          begin
            rd_st_q <= rd_pre ? ddrc_pkg::RD_PRE : ddrc_pkg::RD_IDLE;
            dq_oe <= 1'b0;
            dqs_o <= 1'b0;
            dqs_oe <= rd_pre;
            rd_busy <= 1'b0;
          end
          ddrc_pkg::RD_PRE:
          begin
            rd_st_q <= ddrc_pkg::RD_IDLE;
            dqs_oe <= 1'b0;
          end
          default:
          begin
            rd_st_q <= ddrc_pkg::RD_IDLE;
            dqs_oe <= 1'b0;
          end
        endcase
      end
    end
    else if (fall_ev && rd_st_q == ddrc_pkg::RD_DATA && rd_beat_q != last_beat)
    begin
      rd_beat_q <= rd_beat_q + 3'h1;
      dq_o <= mem_q[rcol_next];
      dqs_o <= 1'b0;
    end
  end

  // ****************************************
  // write path
  // ****************************************
  ddrc_pkg::ddrc_wr_t wr_st_q;
  logic [2:0] wr_beat_q;
  logic [ddrc_pkg::COL_W-1:0] wr_start_q;
  logic pend_q;
  logic [ddrc_pkg::COL_W-1:0] pend_col_q;
  logic wr_switch;
  logic pend_take;

  // the strobe edge expected next alternates with the beat index
  assign wr_cap = (wr_st_q == ddrc_pkg::WR_DATA)
                  && (wr_beat_q[0] ? dqs_f : dqs_r);
  assign wr_switch = wr_cap && (wr_beat_q == last_beat
                     || (bl8 && wr_beat_q == ddrc_pkg::LAST_BL4 && pend_q));
  assign pend_take = pend_q && (wr_switch
                     || (wr_st_q == ddrc_pkg::WR_IDLE && !wr_arm));
  assign wcol = ddrc_pkg::burst_col(wr_start_q, wr_beat_q, bl8, burst_interleave);

  // an arm during a live burst waits here; the set wins over the take
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q <= 1'b0;
      pend_col_q <= '0;
    end
    else if (wr_arm && wr_st_q == ddrc_pkg::WR_DATA)
    begin
      pend_q <= 1'b1;
      pend_col_q <= age_col[wl_m1];
    end
    else if (pend_take)
      pend_q <= 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_st_q <= ddrc_pkg::WR_IDLE;
      wr_beat_q <= 3'h0;
      wr_start_q <= '0;
      wr_busy <= 1'b0;
    end
    else
    begin
      case (wr_st_q)
        ddrc_pkg::WR_IDLE:
        begin
          if (wr_arm || pend_q)
          begin
            wr_st_q <= ddrc_pkg::WR_DATA;
            wr_beat_q <= 3'h0;
            wr_start_q <= wr_arm ? age_col[wl_m1] : pend_col_q;
            wr_busy <= 1'b1;
          end
        end
        ddrc_pkg::WR_DATA:
        begin
          if (wr_switch)
          begin
            wr_beat_q <= 3'h0;
            wr_start_q <= pend_col_q;
            wr_st_q <= pend_q ? ddrc_pkg::WR_DATA : ddrc_pkg::WR_IDLE;
            wr_busy <= pend_q;
          end
          else if (wr_cap)
            wr_beat_q <= wr_beat_q + 3'h1;
        end
        default:
        begin
          wr_st_q <= ddrc_pkg::WR_IDLE;
          wr_busy <= 1'b0;
        end
      endcase
    end
  end

  // storage has no reset: it models the array, not control state
  always_ff @(posedge mclk)
  begin
    if (wr_cap)
      for (int b = 0; b < ddrc_pkg::DM_W; b++)
        if (!dm_s[b])
          mem_q[wcol][b*8 +: 8] <= dqi_s[b*8 +: 8];
  end

  // ****************************************
  // checks
  // ****************************************
  property p_nop_idle;
    @(posedge mclk) disable iff (!nrst)
    rise_ev && !cs_s && ras_s && cas_s && we_s
      |=> prd_q == {$past(prd_q[ddrc_pkg::MAX_RL-1:1]), 1'b0}
      && pwr_q == {$past(pwr_q[ddrc_pkg::MAX_RL-1:1]), 1'b0};
  endproperty
  a_nop_idle: assert property (p_nop_idle) else $error("nop changed state");

  property p_deselect;
    @(posedge mclk) disable iff (!nrst)
    rise_ev && cs_s |=> !prd_q[1] && !pwr_q[1];
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect decoded");

  property p_segment;
    @(posedge mclk) disable iff (!nrst)
    rd_st_q == ddrc_pkg::RD_DATA |-> rcol_next[ddrc_pkg::COL_W-1:3]
      == rd_start_q[ddrc_pkg::COL_W-1:3] && (bl8 || rcol_next[2] == rd_start_q[2]);
  endproperty
  a_segment: assert property (p_segment) else $error("burst left segment");

  property p_read_start;
    @(posedge mclk) disable iff (!nrst)
    rd_due |=> dq_oe && dqs_oe && dqs_o && rd_beat_q == 3'h0;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read data late");

  property p_preamble;
    @(posedge mclk) disable iff (!nrst)
    $rose(dq_oe) |-> $past(dqs_oe) && !$past(dqs_o);
  endproperty
  a_preamble: assert property (p_preamble) else $error("no read preamble");

  property p_strobe_align;
    @(posedge mclk) disable iff (!nrst)
    dq_oe && fall_ev && rd_beat_q[0] == 1'b0 && rd_beat_q != last_beat
      |=> !dqs_o && rd_beat_q[0];
  endproperty
  a_strobe_align: assert property (p_strobe_align) else $error("strobe off data");

  property p_no_capture_idle;
    @(posedge mclk) disable iff (!nrst)
    wr_cap |-> wr_busy;
  endproperty
  a_no_capture_idle: assert property (p_no_capture_idle) else $error("late data taken");

  property p_write_end;
    @(posedge mclk) disable iff (!nrst)
    wr_cap && wr_beat_q == last_beat && !pend_q && !wr_arm |=> !wr_busy;
  endproperty
  a_write_end: assert property (p_write_end) else $error("write ran over");

  property p_write_arm;
    @(posedge mclk) disable iff (!nrst)
    wr_arm && !wr_busy |=> wr_busy && wr_beat_q == 3'h0;
  endproperty
  a_write_arm: assert property (p_write_arm) else $error("write not armed");

endmodule
`default_nettype wire

/* File: tb/ddrc_ctrl_model.sv */
// controller-side model: free running link clock, commands and write strobes
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctrl_model (
  output logic ck, // link clock, 64 ns
  output logic cs_n, // chip select
  output logic ras_n, // row strobe
  output logic cas_n, // column strobe
  output logic we_n, // write enable
  output logic [8:0] col, // start column
  output logic [15:0] dq, // write data
  output logic [1:0] dm, // write mask
  output logic dqs // write strobe
);
  real t_cmd;
  initial
  begin
    ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    col = 9'h0;
    dq = 16'h0;
    dm = 2'h0;
    dqs = 1'b0;
    forever #32 ck = ~ck;
  end
  // no precharge is ever issued, so write recovery is never cut short
  // pins settle half a clock ahead of the registering rise
  task automatic cmd(input logic [3:0] c, input logic [8:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= c;
    col <= a;
    @(posedge ck);
    t_cmd = $realtime;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    col <= ~a;
  endtask
  // data changes a quarter clock before each strobe edge, so it is centred
  task automatic wburst(input int wl, input int n, input logic [15:0] d [8],
    input logic [1:0] m [8]);
    repeat (wl - 1) @(posedge ck);
    @(negedge ck); // strobe held low here as preamble
    for (int k = 0; k < n; k++)
    begin
      #16;
      dq <= d[k];
      dm <= m[k];
      #16;
      dqs <= ~dqs;
    end
    #16;
    dq <= ~dq;
  endtask
endmodule
`default_nettype wire

/* File: tb/ddrc_col_access_bench.sv */
// self-checking bench for the ddr2 column access block
`timescale 1ns/1ps
`default_nettype none
module ddrc_col_access_bench;
  logic mclk, nrst, ck, cs_n, ras_n, cas_n, we_n, il, busy_seen, prev_dqs;
  logic dqs_m, dqs_o, dqs_w, dq_oe, dqs_oe, rd_busy, wr_busy;
  logic [8:0] col;
  logic [15:0] dq_m, dq_o, dq_w;
  logic [1:0] dm;
  logic [2:0] bl, cl, al;
  int bad_count, check_count, cyc;
  logic [15:0] mem [32];
  logic [15:0] q [$];
  real t_dqs, t_dq;
  // whoever enables its driver owns the wire
  assign dq_w = dq_oe ? dq_o : dq_m;
  assign dqs_w = dqs_oe ? dqs_o : dqs_m;
  ddrc_ctrl_model ddrc_ctrl_model_inst (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .col(col), .dq(dq_m), .dm(dm), .dqs(dqs_m));
  ddrc_col_access ddrc_col_access_inst (.mclk(mclk), .nrst(nrst), .ck(ck), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .column_address_bits(col), .dq_i(dq_w),
    .dq_o(dq_o), .dq_oe(dq_oe), .dm_i(dm), .dqs_i(dqs_w), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
    .burst_length(bl), .burst_interleave(il), .cas_latency(cl), .additive_latency(al),
    .rd_busy(rd_busy), .wr_busy(wr_busy));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // a beat is taken on every strobe change while the device drives data
  always @(posedge mclk)
  begin
    if (dqs_oe === 1'b1 && t_dqs == 0)
      t_dqs = $realtime;
    if (dq_oe === 1'b1 && t_dq == 0)
      t_dq = $realtime;
    if (dq_oe === 1'b1 && dqs_o !== prev_dqs)
      q.push_back(dq_o);
    prev_dqs = dqs_o;
    if (rd_busy === 1'b1 || wr_busy === 1'b1 || dq_oe === 1'b1)
      busy_seen = 1'b1;
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [8:0] bcol(logic [8:0] s, logic [2:0] k, logic b8, logic i);
    logic [2:0] lo;
    lo = i ? s[2:0] ^ k : {s[2] ^ k[2], 2'(s[1:0] + k[1:0])};
    if (!b8)
      lo[2] = s[2];
    return {s[8:3], lo};
  endfunction
  task automatic mode(input logic [2:0] a, input logic [2:0] c, input logic b8, input logic i);
    @(posedge mclk);
    al <= a;
    cl <= c;
    bl <= b8 ? 3'h3 : 3'h2;
    il <= i;
  endtask
  task automatic settle(input int n);
    int i;
    for (i = 0; i < 900 && q.size() < n; i++)
      @(posedge mclk);
    for (i = 0; i < 900 && (rd_busy | wr_busy | dq_oe | dqs_oe) !== 1'b0; i++)
      @(posedge mclk);
    check(16'(q.size()), 16'(n));
  endtask
  task automatic rd(input logic [8:0] s, input logic [2:0] a, input logic [2:0] c,
    input logic b8, input logic i);
    real lat;
    mode(a, c, b8, i);
    q = {};
    t_dqs = 0;
    t_dq = 0;
    ddrc_ctrl_model_inst.cmd(4'h5, s);
    settle(b8 ? 8 : 4);
    lat = t_dq - ddrc_ctrl_model_inst.t_cmd;
    check(16'(lat >= (a + c) * 64 && lat <= (a + c) * 64 + 30), 16'h1);
    check(16'(t_dq - t_dqs > 56 && t_dq - t_dqs < 72), 16'h1);
    for (int k = 0; k < (b8 ? 8 : 4); k++)
      check(q[k], mem[bcol(s, 3'(k), b8, i)]);
  endtask
  // x extra beats follow the burst and must not be stored
  task automatic wr(input logic [8:0] s, input logic [2:0] a, input logic [2:0] c,
    input logic b8, input logic i, input logic [1:0] mk, input int x);
    logic [15:0] d [8];
    logic [1:0] m [8];
    logic [8:0] cc;
    for (int k = 0; k < 8; k++)
    begin
      d[k] = 16'h5a00 ^ {s[7:0], 5'h0, 3'(k)};
      m[k] = (k == 1) ? mk : 2'h0;
      cc = bcol(s, 3'(k), b8, i);
      if (k < (b8 ? 8 : 4) && !m[k][0])
        mem[cc][7:0] = d[k][7:0];
      if (k < (b8 ? 8 : 4) && !m[k][1])
        mem[cc][15:8] = d[k][15:8];
    end
    mode(a, c, b8, i);
    busy_seen = 1'b0;
    q = {};
    ddrc_ctrl_model_inst.cmd(4'h4, s);
    ddrc_ctrl_model_inst.wburst(a + c - 1, (b8 ? 8 : 4) + x, d, m);
    settle(0);
    check(16'(busy_seen), 16'h1);
  endtask
  task automatic t_reset();
    check({11'h0, dq_oe, dqs_oe, dqs_o, rd_busy, wr_busy}, 16'h0);
    check(dq_o, 16'h0);
  endtask
  task automatic t_orders();
    wr(9'd16, 3'h0, 3'h3, 1'b1, 1'b0, 2'h0, 0);
    wr(9'd27, 3'h2, 3'h3, 1'b1, 1'b1, 2'h0, 0);
    for (int s = 0; s < 8; s++)
      for (int b = 0; b < 2; b++)
        for (int i = 0; i < 2; i++)
          rd(9'(16 + 8 * i + s), 3'(s % 4), 3'(3 + b + i), b[0], i[0]);
  endtask
  // length 4 from x12 wraps inside its nibble; one byte of beat 1 masked
  task automatic t_mask();
    wr(9'd18, 3'h1, 3'h4, 1'b0, 1'b0, 2'h1, 2);
    rd(9'd16, 3'h1, 3'h4, 1'b1, 1'b0);
  endtask
  // a length-8 read cut by a read exactly two clocks later
  task automatic t_intr();
    mode(3'h0, 3'h3, 1'b1, 1'b0);
    q = {};
    ddrc_ctrl_model_inst.cmd(4'h5, 9'd16);
    ddrc_ctrl_model_inst.cmd(4'h5, 9'd28);
    settle(12);
    for (int k = 0; k < 12; k++)
      check(q[k], mem[k < 4 ? bcol(9'd16, 3'(k), 1'b1, 1'b0) : bcol(9'd28, 3'(k - 4), 1'b1, 1'b0)]);
  endtask
  task automatic t_idle();
    busy_seen = 1'b0;
    ddrc_ctrl_model_inst.cmd(4'h7, 9'd16);
    ddrc_ctrl_model_inst.cmd(4'hd, 9'd16);
    ddrc_ctrl_model_inst.cmd(4'hc, 9'd20);
    repeat (12) @(posedge ck);
    check(16'(busy_seen), 16'h0);
    rd(9'd16, 3'h0, 3'h3, 1'b1, 1'b0);
  endtask
  initial
  begin
    nrst = 1'b0;
    al = 3'h0;
    cl = 3'h3;
    bl = 3'h3;
    il = 1'b0;
    prev_dqs = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_orders();
    t_mask();
    t_intr();
    t_idle();
    give_verdict();
  end
endmodule
`default_nettype wire
